// ---- logic/adc_timing_pkg.sv ----
// constants, fields and states of the converter timing control
// Function
// - basic clock is cpu clock divided by 4, 2, 16 or 8 per select code
// - sample window lasts 8, 16, 32 or 64 basic-clock periods per select code
// - conversion lasts window plus 40 basic periods plus 2 cpu periods exactly
// - after reset a calibration of 3328 basic-clock periods runs
// - conversions during calibration still run and lengthen calibration by their time
// - input below ground gives zero code, above supply gives all-ones ten-bit code
// - input is held when the sample window ends; later changes are ignored
package adc_timing_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RESULT_OFFSET = 12'h008;

  // control word fields
  localparam int CTRL_WIDTH     = 16;
  localparam int DIVSEL_LSB     = 14;
  localparam int SAMPSEL_LSB    = 12;
  localparam int START_BIT      = 7;
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_WIDTH     = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_MASK  = 16'hf00f;

  // status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_CAL_BIT   = 2;

  // result layout
  localparam int CODE_WIDTH     = 10;
  localparam int RES_CHAN_LSB   = 12;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_FULL = 10'h3ff;

  // timing counts
  localparam int CONV_BC_PERIODS = 40;
  localparam int LOAD_CPU_CYCLES = 2;
  localparam int CAL_BC_PERIODS  = 3328;
  localparam int DIV_WIDTH       = 5;
  localparam int WIN_WIDTH       = 7;
  localparam int CAL_WIDTH       = 12;

  typedef enum {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_LOAD
  } conv_state_t;

endpackage

// ---- logic/basic_clock_divider.sv ----
// basic-clock enable generator with selectable ratio
`timescale 1ns/1ps
module basic_clock_divider (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic [1:0] divSel,
  input  wire logic       restart,
  // enable out
  output logic            bcTick
);

  import adc_timing_pkg::*;

  logic [DIV_WIDTH-1:0] cntQ;
  logic [DIV_WIDTH-1:0] cntD;
  logic [DIV_WIDTH-1:0] lastCount;
  logic                 wrapNow;

  // code to ratio minus one
  function automatic logic [DIV_WIDTH-1:0] ratioLast(input logic [1:0] sel);
    case (sel)
      2'b00:   ratioLast = 5'h03;
      2'b01:   ratioLast = 5'h01;
      2'b10:   ratioLast = 5'h0f;
      2'b11:   ratioLast = 5'h07;
      default: ratioLast = 5'h03;
    endcase
  endfunction

  assign lastCount = ratioLast(divSel);
  assign wrapNow   = (cntQ >= lastCount);
  assign cntD      = (restart || wrapNow) ? '0 : cntQ + 5'h01;
  // restart realigns phase so a conversion always spans whole periods
  assign bcTick    = wrapNow && !restart;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntQ <= '0;
    end else begin
      cntQ <= cntD;
    end
  end

endmodule // basic_clock_divider

// ---- logic/adc_conversion_timing_control.sv ----
// converter timing control with apb register access
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module adc_conversion_timing_control #(
  parameter int CAL_PERIODS = adc_timing_pkg::CAL_BC_PERIODS
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  // apb slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [11:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  output logic                                       pready,
  output logic [31:0]                                prdata,
  output logic                                       pslverr,
  // analog front end
  input  wire logic [adc_timing_pkg::CODE_WIDTH-1:0] ainCode,
  input  wire logic                                  ainBelow,
  input  wire logic                                  ainAbove,
  // status
  output logic                                       busy,
  output logic                                       convDone,
  output logic                                       calibrating,
  output logic                                       sampling
);

  import adc_timing_pkg::*;

  // ---------------- input synchronisers
  localparam int SYNC_W = CODE_WIDTH + 2;

  logic [SYNC_W-1:0] syncAQ;
  logic [SYNC_W-1:0] syncBQ;
  logic [SYNC_W-1:0] syncCQ;
  logic [SYNC_W-1:0] ainStableQ;
  logic [SYNC_W-1:0] ainStableD;
  logic [SYNC_W-1:0] ainRaw;

  assign ainRaw = {ainAbove, ainBelow, ainCode};

  // second and third stage must agree before a change is accepted
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      assign ainStableD[gi] = (syncBQ[gi] == syncCQ[gi]) ? syncCQ[gi] : ainStableQ[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncAQ     <= '0;
      syncBQ     <= '0;
      syncCQ     <= '0;
      ainStableQ <= '0;
    end else begin
      syncAQ     <= ainRaw;
      syncBQ     <= syncAQ;
      syncCQ     <= syncBQ;
      ainStableQ <= ainStableD;
    end
  end

  // ---------------- apb decode
  logic        setupPhase;
  logic        accessPhase;
  logic        wrAccess;
  logic        hitCtrl;
  logic        hitStatus;
  logic        hitResult;
  logic        addrMapped;
  logic        wrCtrl;
  logic        wrStatus;
  logic        startReq;
  logic        doneClrReq;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAccess    = accessPhase && pwrite;
  assign hitCtrl     = (paddr == CTRL_OFFSET);
  assign hitStatus   = (paddr == STATUS_OFFSET);
  assign hitResult   = (paddr == RESULT_OFFSET);
  assign addrMapped  = hitCtrl || hitStatus || hitResult;
  assign wrCtrl      = wrAccess && hitCtrl;
  assign wrStatus    = wrAccess && hitStatus;
  assign startReq    = wrCtrl && pwdata[START_BIT];
  assign doneClrReq  = wrStatus && pwdata[STAT_DONE_BIT];

  // ---------------- registers
  logic [CTRL_WIDTH-1:0] ctrlQ;
  logic [CTRL_WIDTH-1:0] ctrlD;
  logic                  pendQ;
  logic                  pendD;
  logic                  doneQ;
  logic                  doneD;
  logic [15:0]           resultQ;
  logic [15:0]           resultD;

  logic [1:0]            cfgDivSel;
  logic [1:0]            cfgSampSel;
  logic [CHAN_WIDTH-1:0] cfgChan;

  // start bit is not stored; it only raises a pending request
  assign ctrlD     = wrCtrl ? (pwdata[CTRL_WIDTH-1:0] & CTRL_MASK) : ctrlQ;
  assign cfgDivSel = ctrlQ[DIVSEL_LSB +: 2];
  assign cfgSampSel = ctrlQ[SAMPSEL_LSB +: 2];
  assign cfgChan   = ctrlQ[CHAN_LSB +: CHAN_WIDTH];

  // ---------------- conversion sequencer
  conv_state_t           stateQ;
  conv_state_t           stateD;
  logic [WIN_WIDTH-1:0]  winCntQ;
  logic [WIN_WIDTH-1:0]  winCntD;
  logic [WIN_WIDTH-1:0]  winLast;
  logic [WIN_WIDTH-1:0]  convLast;
  logic [1:0]            runDivQ;
  logic [1:0]            runSampQ;
  logic [CHAN_WIDTH-1:0] runChanQ;
  logic [CODE_WIDTH-1:0] heldCodeQ;
  logic [CODE_WIDTH-1:0] satCode;
  logic                  bcTick;
  logic                  takeStart;
  logic                  winEnd;
  logic                  convEnd;
  logic                  loadEnd;
  logic                  loadCntQ;
  logic [1:0]            divSelNow;

  // sample window length in basic periods, minus one
  function automatic logic [WIN_WIDTH-1:0] winLastOf(input logic [1:0] sel);
    case (sel)
      2'b00:   winLastOf = 7'h07;
      2'b01:   winLastOf = 7'h0f;
      2'b10:   winLastOf = 7'h1f;
      2'b11:   winLastOf = 7'h3f;
      default: winLastOf = 7'h07;
    endcase
  endfunction

  assign takeStart = (stateQ == ST_IDLE) && pendQ;
  assign winLast   = winLastOf(runSampQ);
  assign convLast  = WIN_WIDTH'(CONV_BC_PERIODS - 1);
  assign winEnd    = (stateQ == ST_SAMPLE) && bcTick && (winCntQ == winLast);
  assign convEnd   = (stateQ == ST_CONVERT) && bcTick && (winCntQ == convLast);
  assign loadEnd   = (stateQ == ST_LOAD) && (loadCntQ == 1'(LOAD_CPU_CYCLES - 1));
  // divider follows the live select while idle, the latched one while running
  assign divSelNow = (stateQ == ST_IDLE) ? cfgDivSel : runDivQ;

  // out-of-range inputs clamp to the end codes
  assign satCode = ainStableQ[CODE_WIDTH]     ? CODE_ZERO :
                   ainStableQ[CODE_WIDTH + 1] ? CODE_FULL :
                   ainStableQ[CODE_WIDTH-1:0];

  basic_clock_divider u_div (
    .clk     (clk),
    .rstn    (rstn),
    .divSel  (divSelNow),
    .restart (takeStart),
    .bcTick  (bcTick)
  );

  always_comb begin
    stateD  = stateQ;
    winCntD = winCntQ;
    case (stateQ)
      ST_IDLE: begin
        if (takeStart) begin
          stateD  = ST_SAMPLE;
          winCntD = '0;
        end
      end
      ST_SAMPLE: begin
        if (winEnd) begin
          stateD  = ST_CONVERT;
          winCntD = '0;
        end else if (bcTick) begin
          winCntD = winCntQ + 7'h01;
        end
      end
      ST_CONVERT: begin
        if (convEnd) begin
          stateD  = ST_LOAD;
          winCntD = '0;
        end else if (bcTick) begin
          winCntD = winCntQ + 7'h01;
        end
      end
      ST_LOAD: begin
        if (loadEnd) begin
          stateD = ST_IDLE;
        end
      end
      default: begin
        stateD  = ST_IDLE;
        winCntD = '0;
      end
    endcase
  end

  // a new start wins over consumption, a done event wins over its clear
  assign pendD   = startReq || (pendQ && !takeStart);
  assign doneD   = loadEnd || (doneQ && !doneClrReq);
  assign resultD = loadEnd ? {runChanQ, 2'b00, heldCodeQ} : resultQ;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateQ   <= ST_IDLE;
      winCntQ  <= '0;
      loadCntQ <= 1'b0;
    end else begin
      stateQ   <= stateD;
      winCntQ  <= winCntD;
      loadCntQ <= (stateQ == ST_LOAD) ? !loadCntQ : 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runDivQ  <= '0;
      runSampQ <= '0;
      runChanQ <= '0;
    end else if (takeStart) begin
      runDivQ  <= cfgDivSel;
      runSampQ <= cfgSampSel;
      runChanQ <= cfgChan;
    end
  end

  // sampled value frozen at window end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      heldCodeQ <= '0;
    end else if (winEnd) begin
      heldCodeQ <= satCode;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlQ   <= CTRL_RESET;
      pendQ   <= 1'b0;
      doneQ   <= 1'b0;
      resultQ <= '0;
    end else begin
      ctrlQ   <= ctrlD;
      pendQ   <= pendD;
      doneQ   <= doneD;
      resultQ <= resultD;
    end
  end

  // ---------------- reset calibration
  logic                  calQ;
  logic [CAL_WIDTH-1:0]  calCntQ;
  logic [CAL_WIDTH-1:0]  calCntD;
  logic                  calStep;
  logic                  calEnd;

  // counting pauses while a conversion runs, stretching calibration
  assign calStep = calQ && bcTick && (stateQ == ST_IDLE) && !pendQ;
  assign calEnd  = calStep && (calCntQ == CAL_WIDTH'(CAL_PERIODS - 1));
  assign calCntD = calStep ? calCntQ + 12'h001 : calCntQ;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calQ    <= 1'b1;
      calCntQ <= '0;
    end else begin
      calCntQ <= calCntD;
      if (calEnd) begin
        calQ <= 1'b0;
      end
    end
  end

  // ---------------- apb read path
  logic [31:0] rdMux;
  logic [15:0] statusWord;

  assign statusWord = {13'h0000, calQ, doneQ, (stateQ != ST_IDLE)};
  assign rdMux = hitCtrl   ? {16'h0000, ctrlQ}      :
                 hitStatus ? {16'h0000, statusWord} :
                 hitResult ? {16'h0000, resultQ}    : 32'h00000000;

  logic errQ;

  // read data captured in the setup cycle, so access needs no wait
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      errQ   <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h00000000 : rdMux;
      errQ   <= !addrMapped;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = accessPhase && errQ;

  // ---------------- status outputs
  assign busy        = (stateQ != ST_IDLE);
  assign convDone    = doneQ;
  assign calibrating = calQ;
  assign sampling    = (stateQ == ST_SAMPLE);

endmodule // adc_conversion_timing_control

// ---- bench/analog_source_model.sv ----
// analog source stand-in driving the front-end inputs
`timescale 1ns/1ps
module analog_source_model (
  // clock
  input  wire logic       clk,
  // level request: 0 in range, 1 under ground, 2 over supply
  input  wire logic [9:0] setCode,
  input  wire logic [1:0] setMode,
  // front end
  output logic [9:0]      ainCode,
  output logic            ainBelow,
  output logic            ainAbove
);
  initial begin
    ainCode = 10'h000;
    ainBelow = 1'b0;
    ainAbove = 1'b0;
  end
  // a source may move at any edge; the converter must cope
  always @(posedge clk) begin
    ainCode <= setCode;
    ainBelow <= (setMode == 2'h1);
    ainAbove <= (setMode == 2'h2);
  end
endmodule // analog_source_model

// ---- bench/adc_conversion_timing_control_checker.sv ----
// port assertions for the converter timing control
`timescale 1ns/1ps
module adc_timing_checker #(
  parameter int CAL_PERIODS = 8
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        busy,
  input wire logic        convDone,
  input wire logic        calibrating,
  input wire logic        sampling
);
  wire logic acc = psel && penable;
  wire logic mapped = paddr inside {12'h000, 12'h004, 12'h008};
  // calibration length in cycles; basic ticks come at most every second cycle
  int calCyclesQ;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calCyclesQ <= 0;
    end else if (calibrating) begin
      calCyclesQ <= calCyclesQ + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  unmapped_error_a: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
  window_min_a: assert property ($rose(sampling) |-> sampling[*8]) else $error("short window");
  start_samples_a: assert property ($rose(busy) |-> sampling) else $error("no window");
  convert_span_a: assert property ($fell(sampling) |-> ##76 busy) else $error("short conv");
  cal_no_return_a: assert property (!calibrating |=> !calibrating) else $error("cal again");
  cal_extend_a: assert property (busy && calibrating |=> calibrating) else $error("cal cut");
  cal_length_a: assert property ($fell(calibrating) |-> calCyclesQ >= 2 * CAL_PERIODS)
    else $error("short calibration");
  hold_busy_a: assert property ($fell(sampling) |-> busy) else $error("early idle");
  sample_busy_a: assert property (sampling |-> busy) else $error("idle window");
  done_at_end_a: assert property ($fell(busy) |-> convDone) else $error("no done");
  cover property ($fell(busy));
  cover property ($fell(calibrating));
  cover property (acc && pslverr);
endmodule // adc_timing_checker
bind adc_conversion_timing_control adc_timing_checker #(.CAL_PERIODS(CAL_PERIODS)) chk (
  .clk, .rstn, .psel, .penable, .paddr, .pslverr, .busy, .convDone, .calibrating, .sampling);

// ---- bench/adc_conversion_timing_control_tb.sv ----
// self-checking bench for the converter timing control
`timescale 1ns/1ps
module adc_conversion_timing_control_tb;
  import adc_timing_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h7ad54c3d;
  logic pready, pslverr, err, busy, convDone, calibrating, sampling;
  logic [9:0] ainCode, setCode = 10'h000;
  logic ainBelow, ainAbove;
  logic [1:0] setMode = 2'h0;
  int mismatches = 0, checked = 0, n;
  int expQ[$];
  always #4 clk = ~clk;
  adc_conversion_timing_control #(.CAL_PERIODS(8)) uut (.clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .ainCode, .ainBelow, .ainAbove,
    .busy, .convDone, .calibrating, .sampling);
  analog_source_model src (.clk, .setCode, .setMode, .ainCode, .ainBelow, .ainAbove);
  function automatic logic [31:0] nxt(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic conv(int d, int s, int m);
    int nb[4] = '{4, 2, 16, 8};
    int sw[4] = '{8, 16, 32, 64};
    logic [3:0] ch;
    int ns;
    seed = nxt(seed); ch = seed[3:0]; setCode <= seed[13:4]; setMode <= m[1:0];
    repeat (6) @(posedge clk);
    expQ.push_back({ch, 2'b00, m == 1 ? 10'h000 : m == 2 ? 10'h3ff : seed[13:4]});
    apb(1, 12'h000, {16'h0, d[1:0], s[1:0], 4'h0, 8'h80 | ch});
    n = 0;
    ns = 0;
    do @(negedge clk); while (busy !== 1'b1);
    while (busy === 1'b1) begin
      if (sampling === 1'b1) begin
        ns++;
      end else begin
        setCode <= ~seed[13:4];
      end
      n++;
      @(negedge clk);
    end
    cmp("busy span", (sw[s] + 40) * nb[d] + 2, n);
    cmp("window span", sw[s] * nb[d], ns);
    @(posedge clk);
    apb(0, 12'h008, 0); cmp("result", expQ.pop_front(), rd);
    apb(0, 12'h004, 0); cmp("done", 2'b10, rd[1:0]);
    cmp("done pin", 1, convDone);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #160000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, 12'h000, 0); cmp("ctrl reset", 0, rd);
    apb(0, 12'h004, 0); cmp("status reset", 4, rd);
    apb(0, 12'h00c, 0); cmp("unmapped err", 1, err);
    $display("reset test done");
    // conversion inside calibration; divider 01 keeps calibration short after it
    conv(1, 0, 0);
    cmp("cal extended", 1, rd[2]);
    n = 0;
    while (calibrating === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    cmp("cal ended", 0, calibrating);
    @(posedge clk);
    apb(1, 12'h004, 2); apb(0, 12'h004, 0); cmp("done clear", 0, rd[1]);
    cmp("done pin clear", 0, convDone);
    $display("calibration test done");
    // basic-clock rate limit is software's duty; the nominal bench clock cannot honour it
    for (int i = 0; i < 16; i++) conv(i / 4, i % 4, i % 3);
    $display("timing sweep done");
    tally_and_finish;
  end
endmodule // adc_conversion_timing_control_tb
